// ---- link_setup_pkg.sv ----
// Shared constants and types for the logical link assignment and setup block.
package link_setup_pkg;
	localparam int LINKS = 8;
	localparam int LW = 3;
	localparam int LLN_W = 13;
	localparam int DLCI_W = 13;
	localparam int CAM_DEPTH = 4;
	localparam logic [DLCI_W-1:0] BCAST_DLCI = 13'h1fff;

	localparam logic [4:0] OFS_CMD = 5'h00;
	localparam logic [4:0] OFS_SEM = 5'h04;
	localparam logic [4:0] OFS_ARG_LINK = 5'h08;
	localparam logic [4:0] OFS_ARG_DLCI = 5'h0c;
	localparam logic [4:0] OFS_ARG_POOL = 5'h10;
	localparam logic [4:0] OFS_CONFIG = 5'h14;
	localparam logic [4:0] OFS_LINK_STAT = 5'h18;
	localparam logic [4:0] OFS_TOP = 5'h1c;

	localparam logic [7:0] SEM_READY = 8'hff;
	localparam logic [7:0] SEM_BUSY = 8'h00;
	localparam logic [7:0] N200_RESET = 8'h03;

	localparam logic [7:0] CMD_POOL_ASSIGN = 8'h01;
	localparam logic [7:0] CMD_ACTIVATE = 8'h02;
	localparam logic [7:0] CMD_ADDR_ASSIGN = 8'h03;
	localparam logic [7:0] CMD_ESTABLISH = 8'h04;
	localparam logic [7:0] CMD_UNNUM_TX = 8'h05;

	localparam logic [3:0] LS_NONE = 4'h0;
	localparam logic [3:0] LS_UNASSIGNED = 4'h1;
	localparam logic [3:0] LS_ASSIGNED = 4'h4;
	localparam logic [3:0] LS_AWAITING_ESTABLISHMENT_STATE = 4'h5;
	localparam logic [3:0] LS_AWAITING_RELEASE_STATE = 4'h6;
	localparam logic [3:0] LS_EST_NORM = 4'h7;

	localparam logic [2:0] FR_UI = 3'h0;
	localparam logic [2:0] FR_SABME = 3'h1;
	localparam logic [2:0] FR_UA = 3'h2;
	localparam logic [2:0] FR_DM = 3'h3;
	localparam logic [2:0] FR_DISC = 3'h4;

	localparam int EV_FULL = 0;
	localparam int EV_PEER = 1;
	localparam int EV_CONF = 2;
	localparam int EV_REL = 3;
	localparam int EV_MERR = 4;
	localparam int EV_DATA = 5;

	localparam int CLK_HZ = 20000000;
	localparam int T200_MS = 1000;
	localparam int T200_CYC = T200_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {T_NONE, T_START, T_STOP} tmr_op_t;
endpackage

// ---- link_lookup_cam.sv ----
// On-chip lookup store pairing an address with a local link number.
module link_lookup_cam import link_setup_pkg::*; (
	// Clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	// Insert
	input  wire logic              i_insert,
	input  wire logic [DLCI_W-1:0] i_dlci,
	input  wire logic [LLN_W-1:0]  i_link,
	// Lookup
	input  wire logic [DLCI_W-1:0] i_find,
	output logic                   o_hit,
	output logic [LLN_W-1:0]       o_link,
	// Status
	output logic                   o_full
);
	typedef struct packed {
		logic [CAM_DEPTH-1:0]             valid;
		logic [CAM_DEPTH-1:0][DLCI_W-1:0] dlci;
		logic [CAM_DEPTH-1:0][LLN_W-1:0]  link;
	} cam_t;
	cam_t s_reg;
	cam_t s_next;
	logic done;

	always_comb begin
		s_next = s_reg;
		done = 1'b0;
		o_hit = 1'b0;
		o_link = '0;
		for (int i = 0; i < CAM_DEPTH; i++) begin
			if (s_reg.valid[i] && s_reg.dlci[i] == i_find) begin
				o_hit = 1'b1;
				o_link = s_reg.link[i];
			end
			if (i_insert && !done && !s_reg.valid[i]) begin
				s_next.valid[i] = 1'b1;
				s_next.dlci[i] = i_dlci;
				s_next.link[i] = i_link;
				done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_full = &s_reg.valid;
endmodule // link_lookup_cam

// ---- t200_timer.sv ----
// Per-link acknowledgement timers with sticky expiry flags.
module t200_timer import link_setup_pkg::*; #(
	parameter int T200_CYCLES = T200_CYC
) (
	// Clock and reset
	input  wire logic           i_mclk,
	input  wire logic           i_rst_n,
	// Control
	input  wire tmr_op_t        i_op,
	input  wire logic [LW-1:0]  i_link,
	// Expiry
	output logic [LINKS-1:0]    o_expired
);
	typedef struct packed {
		logic [LINKS-1:0]        run;
		logic [LINKS-1:0]        exp;
		logic [LINKS-1:0][31:0]  cnt;
	} tmr_t;
	tmr_t s_reg;
	tmr_t s_next;

	always_comb begin
		s_next = s_reg;
		for (int i = 0; i < LINKS; i++) begin
			if (s_reg.run[i]) begin
				if (s_reg.cnt[i] <= 32'h1) begin
					s_next.run[i] = 1'b0;
					s_next.exp[i] = 1'b1;
				end else begin
					s_next.cnt[i] = s_reg.cnt[i] - 32'h1;
				end
			end
		end
		// A restart or stop discards any expiry not yet served.
		if (i_op == T_START) begin
			s_next.run[i_link] = 1'b1;
			s_next.exp[i_link] = 1'b0;
			s_next.cnt[i_link] = 32'(T200_CYCLES);
		end else if (i_op == T_STOP) begin
			s_next.run[i_link] = 1'b0;
			s_next.exp[i_link] = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_expired = s_reg.exp;
endmodule // t200_timer

// ---- link_setup_ctrl.sv ----
// Link activation, address assignment and link setup controller with register slave.
//
// Behaviour
// - The low 3 bits of the 13-bit local link number index per-link context.
// - Activate fetches the link address and loads address/link pair into a free lookup slot.
// - In expanded mode activate writes the link number into the external match table.
// - Activate leaves the link in state 1, unassigned endpoint.
// - Unnumbered transmit request sends the queued frame as a UI frame.
// - Received UI on a link not in state 0 is stored from the link's pool with a data event.
// - Address assign records the link in the store chosen by mode.
// - A full lookup store raises a lookup-full event.
// - Address assign moves state 1 to state 4; other states stay.
// - Establish is accepted in any state, even before assignment.
// - Accepted peer SABME sends UA and clears counters, busy flag and variables.
// - Accepted peer SABME restarts activity timer, updates top link, signals setup.
// - SABME while awaiting release is answered with DM, state kept.
// - Establish sends SABME, starts T200, clears count, enters state 5.
// - UA in state 5 establishes the link, confirms, clears busy and variables.
// - DM in state 5 stops T200 and signals release.
// - In state 5 UI is still stored as data; SABME or DISC is a collision.
// - T200 expiry in state 5 resends SABME, restarts T200, counts a retry.
// - At the retry limit T200 stops with release and management error events.
//
// Design decisions made here: the Avalon-MM register port and the address map.
module link_setup_ctrl import link_setup_pkg::*; #(
	parameter int T200_CYCLES = T200_CYC
) (
	// Clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_rst_n,
	// Avalon-MM slave
	input  wire logic [4:0]        i_avm_address,
	input  wire logic              i_avm_read,
	input  wire logic              i_avm_write,
	input  wire logic [31:0]       i_avm_writedata,
	input  wire logic [3:0]        i_avm_byteenable,
	output logic [31:0]            o_avm_readdata,
	output logic                   o_avm_waitrequest,
	// Received frames
	input  wire logic              i_rx_valid,
	input  wire logic [2:0]        i_rx_kind,
	input  wire logic [DLCI_W-1:0] i_rx_dlci,
	input  wire logic [LLN_W-1:0]  i_rx_link,
	// Frames to send
	output logic                   o_tx_valid,
	output logic [2:0]             o_tx_kind,
	output logic [LLN_W-1:0]       o_tx_link,
	// External match table write
	output logic                   o_match_we,
	output logic [DLCI_W-1:0]      o_match_addr,
	output logic [LLN_W-1:0]       o_match_data,
	// Events and receive storage
	output logic [5:0]             o_event,
	output logic [LLN_W-1:0]       o_event_link,
	output logic                   o_store_valid,
	output logic [7:0]             o_store_pool,
	output logic                   o_activity_restart,
	output logic [LLN_W-1:0]       o_activity_link
);
	typedef struct packed {
		logic                          waitreq;
		logic [31:0]                   rdata;
		logic [7:0]                    cmd;
		logic [7:0]                    sem;
		logic                          cmd_pend;
		logic [LLN_W-1:0]              arg_link;
		logic [DLCI_W-1:0]             arg_dlci;
		logic [7:0]                    arg_pool;
		logic                          expanded;
		logic [7:0]                    n200;
		logic [LLN_W-1:0]              top;
		logic [LINKS-1:0][3:0]         lstate;
		logic [LINKS-1:0][7:0]         retx;
		logic [LINKS-1:0]              rbusy;
		logic [LINKS-1:0][6:0]         vs;
		logic [LINKS-1:0][6:0]         vr;
		logic [LINKS-1:0][6:0]         va;
		logic [LINKS-1:0][7:0]         pool;
		logic                          tx_valid;
		logic [2:0]                    tx_kind;
		logic [LLN_W-1:0]              tx_link;
		logic                          match_we;
		logic [DLCI_W-1:0]             match_addr;
		logic [LLN_W-1:0]              match_data;
		logic [5:0]                    event_bits;
		logic [LLN_W-1:0]              event_link;
		logic                          store_valid;
		logic [7:0]                    store_pool;
		logic                          act_restart;
		logic [LLN_W-1:0]              act_link;
		logic                          cam_ins;
		logic [DLCI_W-1:0]             cam_dlci;
		logic [LLN_W-1:0]              cam_link;
		tmr_op_t                       t_op;
		logic [LW-1:0]                 t_link;
	} ctrl_t;
	ctrl_t s_reg;
	ctrl_t s_next;

	logic [LINKS-1:0]  t_expired;
	logic              cam_full;
	logic              cam_hit;
	logic [LLN_W-1:0]  cam_link;
	logic              do_rx;
	logic              do_tmr;
	logic              do_cmd;
	logic [LW-1:0]     aidx;
	logic [LW-1:0]     ridx;
	logic [LW-1:0]     tidx;
	logic [LLN_W-1:0]  rlink;
	logic [31:0]       rd;
	logic [31:0]       wd;

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [LLN_W-1:0] top_of(input logic [LLN_W-1:0] top, input logic [LLN_W-1:0] link);
		return (link > top) ? link : top;
	endfunction

	link_lookup_cam u_cam (
		.i_mclk   (i_mclk),
		.i_rst_n  (i_rst_n),
		.i_insert (s_reg.cam_ins),
		.i_dlci   (s_reg.cam_dlci),
		.i_link   (s_reg.cam_link),
		.i_find   (i_rx_dlci),
		.o_hit    (cam_hit),
		.o_link   (cam_link),
		.o_full   (cam_full)
	);

	t200_timer #(.T200_CYCLES(T200_CYCLES)) u_t200 (
		.i_mclk    (i_mclk),
		.i_rst_n   (i_rst_n),
		.i_op      (s_reg.t_op),
		.i_link    (s_reg.t_link),
		.o_expired (t_expired)
	);

	always_comb begin
		s_next = s_reg;
		s_next.tx_valid = 1'b0;
		s_next.match_we = 1'b0;
		s_next.event_bits = '0;
		s_next.store_valid = 1'b0;
		s_next.act_restart = 1'b0;
		s_next.cam_ins = 1'b0;
		s_next.t_op = T_NONE;
		aidx = s_reg.arg_link[LW-1:0];
		rlink = s_reg.expanded ? i_rx_link : cam_link;
		ridx = rlink[LW-1:0];
		tidx = '0;
		for (int i = LINKS - 1; i >= 0; i--) begin
			if (t_expired[i]) begin
				tidx = LW'(i);
			end
		end
		do_rx = i_rx_valid && (s_reg.expanded || cam_hit);
		// Expiry flags lag a timer command by one cycle, so none is served then.
		do_tmr = !do_rx && (|t_expired) && s_reg.t_op == T_NONE;
		do_cmd = !do_rx && !do_tmr && s_reg.cmd_pend;

		case (i_avm_address)
			OFS_CMD: rd = {24'h0, s_reg.cmd};
			OFS_SEM: rd = {24'h0, s_reg.sem};
			OFS_ARG_LINK: rd = {19'h0, s_reg.arg_link};
			OFS_ARG_DLCI: rd = {19'h0, s_reg.arg_dlci};
			OFS_ARG_POOL: rd = {24'h0, s_reg.arg_pool};
			OFS_CONFIG: rd = {16'h0, s_reg.n200, 7'h0, s_reg.expanded};
			OFS_LINK_STAT: rd = {3'h0, s_reg.va[aidx], s_reg.vr[aidx], s_reg.vs[aidx], 3'h0, s_reg.rbusy[aidx],
				s_reg.lstate[aidx]};
			OFS_TOP: rd = {8'h0, s_reg.retx[aidx], 3'h0, s_reg.top};
			default: rd = 32'h0;
		endcase
		wd = be_merge(rd, i_avm_writedata, i_avm_byteenable);

		// First cycle of a request raises the answer; the write lands on the next edge.
		s_next.waitreq = !((i_avm_read || i_avm_write) && s_reg.waitreq);
		if ((i_avm_read || i_avm_write) && s_reg.waitreq) begin
			s_next.rdata = rd;
		end
		if (i_avm_write && !s_reg.waitreq) begin
			case (i_avm_address)
				OFS_CMD: begin
					// Commands while busy are dropped; software must poll first.
					if (s_reg.sem == SEM_READY) begin
						s_next.cmd = wd[7:0];
						s_next.cmd_pend = 1'b1;
						s_next.sem = SEM_BUSY;
					end
				end
				OFS_ARG_LINK: s_next.arg_link = wd[LLN_W-1:0];
				OFS_ARG_DLCI: s_next.arg_dlci = wd[DLCI_W-1:0];
				OFS_ARG_POOL: s_next.arg_pool = wd[7:0];
				OFS_CONFIG: begin
					s_next.expanded = wd[0];
					s_next.n200 = wd[15:8];
				end
				OFS_LINK_STAT: begin
					s_next.rbusy[aidx] = wd[4];
					s_next.vs[aidx] = wd[14:8];
					s_next.vr[aidx] = wd[21:15];
					s_next.va[aidx] = wd[28:22];
				end
				default: ;
			endcase
		end

		if (do_rx) begin
			s_next.event_link = rlink;
			s_next.tx_link = rlink;
			case (i_rx_kind)
				FR_UI: begin
					if (s_reg.lstate[ridx] != LS_NONE) begin
						s_next.store_valid = 1'b1;
						s_next.store_pool = s_reg.pool[ridx];
						s_next.event_bits[EV_DATA] = 1'b1;
					end
				end
				FR_SABME: begin
					s_next.tx_valid = 1'b1;
					if (s_reg.lstate[ridx] == LS_ASSIGNED || s_reg.lstate[ridx] == LS_EST_NORM) begin
						s_next.tx_kind = FR_UA;
						s_next.retx[ridx] = '0;
						s_next.rbusy[ridx] = 1'b0;
						s_next.vs[ridx] = '0;
						s_next.vr[ridx] = '0;
						s_next.va[ridx] = '0;
						s_next.act_restart = 1'b1;
						s_next.act_link = rlink;
						s_next.top = top_of(s_reg.top, rlink);
						s_next.lstate[ridx] = LS_EST_NORM;
						s_next.event_bits[EV_PEER] = 1'b1;
					end else if (s_reg.lstate[ridx] == LS_AWAITING_ESTABLISHMENT_STATE) begin
						s_next.tx_kind = FR_UA;
					end else begin
						s_next.tx_kind = FR_DM;
					end
				end
				FR_UA: begin
					if (s_reg.lstate[ridx] == LS_AWAITING_ESTABLISHMENT_STATE) begin
						s_next.lstate[ridx] = LS_EST_NORM;
						s_next.event_bits[EV_CONF] = 1'b1;
						s_next.rbusy[ridx] = 1'b0;
						s_next.vs[ridx] = '0;
						s_next.vr[ridx] = '0;
						s_next.va[ridx] = '0;
						s_next.t_op = T_STOP;
						s_next.t_link = ridx;
					end
				end
				FR_DM: begin
					if (s_reg.lstate[ridx] == LS_AWAITING_ESTABLISHMENT_STATE) begin
						s_next.t_op = T_STOP;
						s_next.t_link = ridx;
						s_next.event_bits[EV_REL] = 1'b1;
						s_next.lstate[ridx] = LS_ASSIGNED;
					end
				end
				FR_DISC: begin
					if (s_reg.lstate[ridx] == LS_AWAITING_ESTABLISHMENT_STATE) begin
						s_next.tx_valid = 1'b1;
						s_next.tx_kind = FR_DM;
					end
				end
				default: ;
			endcase
		end else if (do_tmr) begin
			s_next.t_link = tidx;
			s_next.t_op = T_STOP;
			if (s_reg.lstate[tidx] == LS_AWAITING_ESTABLISHMENT_STATE) begin
				s_next.event_link = LLN_W'(tidx);
				if (s_reg.retx[tidx] >= s_reg.n200) begin
					s_next.event_bits[EV_REL] = 1'b1;
					s_next.event_bits[EV_MERR] = 1'b1;
					s_next.lstate[tidx] = LS_ASSIGNED;
				end else begin
					s_next.t_op = T_START;
					s_next.retx[tidx] = s_reg.retx[tidx] + 8'h1;
					s_next.tx_valid = 1'b1;
					s_next.tx_kind = FR_SABME;
					s_next.tx_link = LLN_W'(tidx);
				end
			end
		end else if (do_cmd) begin
			s_next.cmd_pend = 1'b0;
			s_next.sem = SEM_READY;
			s_next.event_link = s_reg.arg_link;
			s_next.tx_link = s_reg.arg_link;
			case (s_reg.cmd)
				CMD_POOL_ASSIGN: s_next.pool[aidx] = s_reg.arg_pool;
				CMD_ACTIVATE, CMD_ADDR_ASSIGN: begin
					if (s_reg.expanded) begin
						s_next.match_we = 1'b1;
						s_next.match_addr = s_reg.arg_dlci;
						s_next.match_data = s_reg.arg_link;
					end else if (cam_full) begin
						s_next.event_bits[EV_FULL] = 1'b1;
					end else begin
						s_next.cam_ins = 1'b1;
						s_next.cam_dlci = s_reg.arg_dlci;
						s_next.cam_link = s_reg.arg_link;
					end
					if (s_reg.cmd == CMD_ACTIVATE) begin
						s_next.lstate[aidx] = LS_UNASSIGNED;
					end else if (s_reg.lstate[aidx] == LS_UNASSIGNED) begin
						s_next.lstate[aidx] = LS_ASSIGNED;
					end
				end
				CMD_ESTABLISH: begin
					s_next.tx_valid = 1'b1;
					s_next.tx_kind = FR_SABME;
					s_next.t_op = T_START;
					s_next.t_link = aidx;
					s_next.top = top_of(s_reg.top, s_reg.arg_link);
					s_next.retx[aidx] = '0;
					s_next.lstate[aidx] = LS_AWAITING_ESTABLISHMENT_STATE;
				end
				CMD_UNNUM_TX: begin
					s_next.tx_valid = 1'b1;
					s_next.tx_kind = FR_UI;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			s_reg <= '0;
			s_reg.waitreq <= 1'b1;
			s_reg.sem <= SEM_READY;
			s_reg.n200 <= N200_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_avm_readdata = s_reg.rdata;
	assign o_avm_waitrequest = s_reg.waitreq;
	assign o_tx_valid = s_reg.tx_valid;
	assign o_tx_kind = s_reg.tx_kind;
	assign o_tx_link = s_reg.tx_link;
	assign o_match_we = s_reg.match_we;
	assign o_match_addr = s_reg.match_addr;
	assign o_match_data = s_reg.match_data;
	assign o_event = s_reg.event_bits;
	assign o_event_link = s_reg.event_link;
	assign o_store_valid = s_reg.store_valid;
	assign o_store_pool = s_reg.store_pool;
	assign o_activity_restart = s_reg.act_restart;
	assign o_activity_link = s_reg.act_link;

	a_activate_state: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && s_reg.cmd == CMD_ACTIVATE |=> s_reg.lstate[aidx] == LS_UNASSIGNED && s_reg.sem == SEM_READY)
		else $error("activate did not leave link unassigned");
	a_assign_promote: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && s_reg.cmd == CMD_ADDR_ASSIGN && s_reg.lstate[aidx] == LS_UNASSIGNED
		|=> s_reg.lstate[aidx] == LS_ASSIGNED)
		else $error("assign did not move link to assigned");
	a_assign_keep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && s_reg.cmd == CMD_ADDR_ASSIGN && s_reg.lstate[aidx] != LS_UNASSIGNED
		|=> $stable(s_reg.lstate[aidx]))
		else $error("assign changed a link not unassigned");
	a_match_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && (s_reg.cmd == CMD_ACTIVATE || s_reg.cmd == CMD_ADDR_ASSIGN) && s_reg.expanded
		|=> o_match_we && o_match_data == $past(s_reg.arg_link) && o_match_addr == $past(s_reg.arg_dlci) ##1 !o_match_we)
		else $error("match table write missing");
	a_lookup_full: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && (s_reg.cmd == CMD_ACTIVATE || s_reg.cmd == CMD_ADDR_ASSIGN) && !s_reg.expanded && cam_full
		|=> o_event[EV_FULL] && !s_reg.cam_ins)
		else $error("lookup full event missing");
	a_establish_send: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_cmd && s_reg.cmd == CMD_ESTABLISH
		|=> o_tx_valid && o_tx_kind == FR_SABME && s_reg.t_op == T_START && s_reg.retx[aidx] == 8'h0
		&& s_reg.lstate[aidx] == LS_AWAITING_ESTABLISHMENT_STATE)
		else $error("establish request mishandled");
	a_peer_accept: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_rx && i_rx_kind == FR_SABME && s_reg.lstate[ridx] == LS_ASSIGNED
		|=> o_tx_kind == FR_UA && o_event[EV_PEER] && o_activity_restart && s_reg.lstate[$past(ridx)] == LS_EST_NORM)
		else $error("peer setup not accepted");
	a_release_refuse: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_rx && i_rx_kind == FR_SABME && s_reg.lstate[ridx] != LS_ASSIGNED && s_reg.lstate[ridx] != LS_AWAITING_ESTABLISHMENT_STATE
		&& s_reg.lstate[ridx] != LS_EST_NORM
		|=> o_tx_valid && o_tx_kind == FR_DM && !o_event[EV_PEER]
		&& s_reg.lstate[$past(ridx)] == $past(s_reg.lstate[ridx]))
		else $error("sabme while releasing not refused");
	a_confirm_ua: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_rx && i_rx_kind == FR_UA && s_reg.lstate[ridx] == LS_AWAITING_ESTABLISHMENT_STATE
		|=> o_event[EV_CONF] && s_reg.vs[$past(ridx)] == 7'h0 && s_reg.lstate[$past(ridx)] == LS_EST_NORM)
		else $error("ua did not confirm setup");
	a_retry_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		do_tmr && s_reg.lstate[tidx] == LS_AWAITING_ESTABLISHMENT_STATE && s_reg.retx[tidx] >= s_reg.n200
		|=> o_event[EV_REL] && o_event[EV_MERR] && s_reg.t_op == T_STOP && !o_tx_valid)
		else $error("retry limit not reported");
endmodule // link_setup_ctrl

// ---- remote_station.sv ----
// Behavioural remote link station that answers link setup frames.
module remote_station import link_setup_pkg::*; (
	// Clock
	input  wire logic              i_mclk,
	// Frames sent by the block
	input  wire logic              i_tx_valid,
	input  wire logic [2:0]        i_tx_kind,
	input  wire logic [LLN_W-1:0]  i_tx_link,
	// Bench control: 0 silent, 1 UA, 2 DM
	input  wire logic [1:0]        i_reply,
	input  wire logic              i_send,
	input  wire logic [2:0]        i_send_kind,
	input  wire logic [DLCI_W-1:0] i_send_dlci,
	input  wire logic [LLN_W-1:0]  i_send_link,
	// Frames received by the block
	output logic                   o_rx_valid = 1'b0,
	output logic [2:0]             o_rx_kind = 3'h7,
	output logic [DLCI_W-1:0]      o_rx_dlci = 13'h0,
	output logic [LLN_W-1:0]       o_rx_link = 13'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic             pend = 1'b0;
	logic [LLN_W-1:0] plink = 13'h0;
	// Outside a frame the lines toggle so that stale values are never trusted.
	always @(posedge i_mclk) begin
		pend <= i_tx_valid && i_tx_kind == FR_SABME && i_reply != 2'h0;
		plink <= i_tx_link;
		o_rx_valid <= pend || i_send;
		o_rx_kind <= pend ? (i_reply == 2'h1 ? FR_UA : FR_DM) : (i_send ? i_send_kind : ~o_rx_kind);
		o_rx_link <= pend ? plink : (i_send ? i_send_link : ~o_rx_link);
		o_rx_dlci <= i_send ? i_send_dlci : ~o_rx_dlci;
	end
endmodule // remote_station

// ---- tb_link_setup_ctrl.sv ----
// Self-checking bench for the link setup controller.
module tb_link_setup_ctrl import link_setup_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 0, i_rst_n = 0, i_avm_read = 0, i_avm_write = 0, snd = 0;
	logic [4:0] i_avm_address = 5'h0;
	logic [31:0] i_avm_writedata = 32'h0, o_avm_readdata;
	logic o_avm_waitrequest, rx_v, o_tx_valid, o_match_we, o_store_valid, o_act;
	logic [2:0] rx_k, o_tx_kind, snd_k = 3'h0, tx_k;
	logic [12:0] rx_d, rx_l, o_tx_link, m_a, m_d, o_match_addr, o_match_data, o_ev_link, o_act_link, a_l, e_l;
	logic [12:0] snd_d = 13'h0, snd_l = 13'h0;
	logic [1:0] reply = 2'h0;
	logic [5:0] o_event, ev_acc = 6'h0;
	logic [7:0] o_store_pool, s_pool;
	logic [31:0] q;
	int n_mismatch = 0, check_count = 0, n_sabme = 0;
	link_setup_ctrl #(.T200_CYCLES(20)) i_link_setup_ctrl (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_avm_address(i_avm_address), .i_avm_read(i_avm_read), .i_avm_write(i_avm_write),
		.i_avm_writedata(i_avm_writedata), .i_avm_byteenable(4'hf), .o_avm_readdata(o_avm_readdata),
		.o_avm_waitrequest(o_avm_waitrequest), .i_rx_valid(rx_v), .i_rx_kind(rx_k), .i_rx_dlci(rx_d),
		.i_rx_link(rx_l), .o_tx_valid(o_tx_valid), .o_tx_kind(o_tx_kind), .o_tx_link(o_tx_link),
		.o_match_we(o_match_we), .o_match_addr(o_match_addr), .o_match_data(o_match_data),
		.o_event(o_event), .o_event_link(o_ev_link), .o_store_valid(o_store_valid),
		.o_store_pool(o_store_pool), .o_activity_restart(o_act), .o_activity_link(o_act_link));
	remote_station i_remote_station (.i_mclk(i_mclk), .i_tx_valid(o_tx_valid), .i_tx_kind(o_tx_kind),
		.i_tx_link(o_tx_link), .i_reply(reply), .i_send(snd), .i_send_kind(snd_k), .i_send_dlci(snd_d),
		.i_send_link(snd_l), .o_rx_valid(rx_v), .o_rx_kind(rx_k), .o_rx_dlci(rx_d), .o_rx_link(rx_l));
	initial begin
		forever #25 i_mclk = ~i_mclk;
	end
	// Pulses are caught on the falling edge, clear of the bench's own updates.
	always @(negedge i_mclk) begin
		ev_acc <= ev_acc | o_event;
		if (o_tx_valid === 1'b1) begin
			tx_k <= o_tx_kind;
			n_sabme <= n_sabme + (o_tx_kind === FR_SABME ? 1 : 0);
		end
		if (o_match_we === 1'b1) begin
			m_a <= o_match_addr;
			m_d <= o_match_data;
		end
		if (o_store_valid === 1'b1) s_pool <= o_store_pool;
		if (o_act === 1'b1) a_l <= o_act_link;
		if (o_event !== 6'h0) e_l <= o_ev_link;
	end
	task end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task guard(input int n);
		if (n >= 400) begin
			n_mismatch++;
			$display("unexpected at %0t: wait timed out", $time);
			end_sim();
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge i_mclk);
		i_avm_address <= a;
		i_avm_write <= w;
		i_avm_read <= !w;
		i_avm_writedata <= d;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_avm_waitrequest !== 1'b0 && n < 400);
		guard(n);
		q = o_avm_readdata;
		i_avm_read <= 1'b0;
		i_avm_write <= 1'b0;
	endtask
	task poll();
		int n;
		n = 0;
		do begin
			bus(0, OFS_SEM, 32'h0);
			n++;
		end while (q[7:0] !== SEM_READY && n < 400);
		guard(n);
	endtask
	task cmd(input logic [7:0] c, input logic [12:0] lk, input logic [12:0] dl);
		ev_acc = 6'h0;
		poll();
		bus(1, OFS_ARG_LINK, {19'h0, lk});
		bus(1, OFS_ARG_DLCI, {19'h0, dl});
		bus(1, OFS_CMD, {24'h0, c});
		poll();
	endtask
	task st(input logic [12:0] lk, input logic [3:0] e);
		bus(1, OFS_ARG_LINK, {19'h0, lk});
		bus(0, OFS_LINK_STAT, 32'h0);
		chk(q, {28'h0, e});
	endtask
	task send(input logic [2:0] k, input logic [12:0] dl);
		ev_acc = 6'h0;
		@(posedge i_mclk);
		snd <= 1'b1;
		snd_k <= k;
		snd_d <= dl;
		@(posedge i_mclk);
		snd <= 1'b0;
		repeat (3) @(posedge i_mclk);
	endtask
	task wait_ev(input int b);
		int n;
		for (n = 0; n < 400 && ev_acc[b] !== 1'b1; n++) @(posedge i_mclk);
		guard(n);
	endtask
	initial begin
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		bus(0, OFS_SEM, 32'h0);
		chk(q, {24'h0, SEM_READY});
		bus(1, OFS_ARG_POOL, 32'h5);
		cmd(CMD_POOL_ASSIGN, 13'h1, 13'h0);
		cmd(CMD_ACTIVATE, 13'h1, BCAST_DLCI);
		st(13'h1, LS_UNASSIGNED);
		cmd(CMD_ADDR_ASSIGN, 13'h1, BCAST_DLCI);
		st(13'h1, LS_ASSIGNED);
		cmd(CMD_ADDR_ASSIGN, 13'h2, 13'h10);
		st(13'h2, LS_NONE);
		for (int k = 3; k < 7; k++) cmd(CMD_ADDR_ASSIGN, k[12:0], 13'h20 + k[12:0]);
		chk({31'h0, ev_acc[EV_FULL] | o_event[EV_FULL]}, 32'h1);
		bus(1, OFS_ARG_LINK, 32'h1);
		bus(1, OFS_LINK_STAT, 32'h0040_0010);
		bus(0, OFS_LINK_STAT, 32'h0);
		chk(q, 32'h0040_0014);
		send(FR_SABME, BCAST_DLCI);
		chk({29'h0, tx_k}, {29'h0, FR_UA});
		chk({19'h0, a_l, ev_acc}, {19'h0, 13'h1, 6'h2});
		st(13'h1, LS_EST_NORM);
		bus(0, OFS_TOP, 32'h0);
		chk(q, 32'h1);
		send(FR_UI, BCAST_DLCI);
		chk({18'h0, s_pool, ev_acc}, {18'h0, 8'h5, 6'h20});
		cmd(CMD_UNNUM_TX, 13'h1, 13'h0);
		chk({29'h0, tx_k}, {29'h0, FR_UI});
		bus(1, OFS_CONFIG, 32'h0301);
		cmd(CMD_ACTIVATE, 13'h2, 13'h0abc);
		chk({6'h0, m_a, m_d}, {6'h0, 13'h0abc, 13'h2});
		snd_l <= 13'h2;
		send(FR_SABME, 13'h0);
		chk({23'h0, tx_k, ev_acc}, {23'h0, FR_DM, 6'h0});
		st(13'h2, LS_UNASSIGNED);
		n_sabme = 0;
		cmd(CMD_ESTABLISH, 13'h4, 13'h0);
		st(13'h4, LS_AWAITING_ESTABLISHMENT_STATE);
		wait_ev(EV_REL);
		chk(n_sabme, 4);
		chk({26'h0, ev_acc}, 32'h18);
		reply <= 2'h2;
		cmd(CMD_ESTABLISH, 13'h5, 13'h0);
		wait_ev(EV_REL);
		chk({13'h0, e_l, ev_acc}, {13'h0, 13'h5, 6'h08});
		st(13'h5, LS_ASSIGNED);
		reply <= 2'h1;
		cmd(CMD_ESTABLISH, 13'h3, 13'h0);
		wait_ev(EV_CONF);
		st(13'h3, LS_EST_NORM);
		end_sim();
	end
endmodule // tb_link_setup_ctrl
